// ===== rtl/tic_consts.vh
// constants for the 16-bit input-capture timer
`ifndef TIC_CONSTS_VH
`define TIC_CONSTS_VH

// ********************************
// register byte addresses
// ********************************
`define TIC_ADDR_COUNT 5'h00
`define TIC_ADDR_CAPTURE 5'h04
`define TIC_ADDR_COMPARE1 5'h08
`define TIC_ADDR_CTRL0 5'h0c
`define TIC_ADDR_CTRL1 5'h10
`define TIC_ADDR_STATUS 5'h14

// ********************************
// first_control_reg fields
// ********************************
`define TIC_C0_RUN 0
`define TIC_C0_CLK_LO 1
`define TIC_C0_CLK_HI 2
`define TIC_C0_EDGE_LO 3
`define TIC_C0_EDGE_HI 4
`define TIC_C0_MASK 32'h0000_001f

// ********************************
// second_control_reg fields
// ********************************
`define TIC_C1_FILT_LO 0
`define TIC_C1_FILT_HI 1
`define TIC_C1_FILT_EN 2
`define TIC_C1_MODE 3
`define TIC_C1_COMPARE_CLEAR_BIT 4
`define TIC_C1_OCFG_LO 5
`define TIC_C1_OCFG_HI 8
`define TIC_C1_MASK 32'h0000_01ff

// ********************************
// status fields (write 1 to clear)
// ********************************
`define TIC_ST_CAP 0
`define TIC_ST_OVF 1

// ********************************
// encodings and counts
// ********************************
`define TIC_CLK_F1 2'h0
`define TIC_CLK_F8 2'h1
`define TIC_CLK_F32 2'h2
`define TIC_EDGE_RISE 2'h0
`define TIC_EDGE_FALL 2'h1
`define TIC_EDGE_BOTH 2'h2
`define TIC_DIV8_LAST 3'h7
`define TIC_DIV32_LAST 5'h1f
`define TIC_COUNT_MAX 16'hffff
`define TIC_COUNT_ZERO 16'h0000
`define TIC_FILT_FULL 2'h2
`define TIC_RESP_OKAY 2'h0
`define TIC_RESP_SLVERR 2'h2
`define TIC_ZERO32 32'h0000_0000

`endif

// ===== rtl/tic_timer.v
// 16-bit input-capture timer with axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tic_consts.vh"

// register map, byte addresses: 0x00 count, 0x04 capture, 0x08 compare-1,
// 0x0c first control, 0x10 second control, 0x14 status (write 1 to clear)
// limitation: the compare waveform is not built, compare settings are stored only

module tic_timer (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire measured_pulse_in,
    output reg capture_irq_pulse,
    output reg overflow_irq_pulse,
    output reg compare_output_oe
);

// ********************************
// registers
// ********************************
reg [15:0] timer_count_reg;
reg [15:0] capture_value_reg;
reg [15:0] compare1_value_reg;
reg [31:0] first_control_reg;
reg [31:0] second_control_reg;
reg [1:0] status_reg;
reg [4:0] prescale_reg;
reg [4:0] fprescale_reg;
reg pin_sync1_reg;
reg pin_sync2_reg;
reg [1:0] match_cnt_reg;
reg filt_level_reg;
reg filt_prev_reg;
reg [4:0] aw_addr_reg;
reg aw_held_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_held_reg;

wire count_run_bit = first_control_reg[`TIC_C0_RUN];
wire [1:0] clk_sel = first_control_reg[`TIC_C0_CLK_HI:`TIC_C0_CLK_LO];
wire [1:0] edge_polarity_sel = first_control_reg[`TIC_C0_EDGE_HI:`TIC_C0_EDGE_LO];
wire [1:0] filter_clock_sel = second_control_reg[`TIC_C1_FILT_HI:`TIC_C1_FILT_LO];
wire filter_en = second_control_reg[`TIC_C1_FILT_EN];
wire mode_select_bit = second_control_reg[`TIC_C1_MODE];

// tick generation; f1 ticks every aclk, shared by counter and filter
function tick_of;
    input [1:0] sel;
    input [4:0] pre;
    begin
        case (sel)
            `TIC_CLK_F1: tick_of = 1'b1;
            `TIC_CLK_F8: tick_of = (pre[2:0] == `TIC_DIV8_LAST);
            `TIC_CLK_F32: tick_of = (pre == `TIC_DIV32_LAST);
            default: tick_of = 1'b1;
        endcase
    end
endfunction

// write merge with byte strobes
function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    end
endfunction

wire count_tick = tick_of(clk_sel, prescale_reg);
wire filt_tick = tick_of(filter_clock_sel, fprescale_reg);

// ********************************
// input filter and edge detect
// ********************************
// sync2 only is read by logic; sync1 feeds sync2 alone to keep metastability out
wire in_level = filter_en ? filt_level_reg : pin_sync2_reg;
wire rise = in_level & ~filt_prev_reg;
wire fall = ~in_level & filt_prev_reg;
reg valid_edge;
always @* begin
    case (edge_polarity_sel)
        `TIC_EDGE_RISE: valid_edge = rise;
        `TIC_EDGE_FALL: valid_edge = fall;
        `TIC_EDGE_BOTH: valid_edge = rise | fall;
        default: valid_edge = 1'b0;
    endcase
end
// capture only while counting in capture mode
wire capture_hit = valid_edge & count_run_bit & ~mode_select_bit;
// overflow fires on the tick that takes the count from its maximum back to zero
wire overflow_hit = count_run_bit & count_tick & (timer_count_reg == `TIC_COUNT_MAX);

// ********************************
// bus decode
// ********************************
// a write commits only once both halves are held; committing on the raw
// valids would apply a status clear again on every cycle of a stalled write
wire [4:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
wire wr_ctrl0 = wr_fire & (wr_addr == `TIC_ADDR_CTRL0);
wire wr_ctrl1 = wr_fire & (wr_addr == `TIC_ADDR_CTRL1);
wire wr_cmp1 = wr_fire & (wr_addr == `TIC_ADDR_COMPARE1);
wire wr_stat = wr_fire & (wr_addr == `TIC_ADDR_STATUS);
wire wr_known = wr_ctrl0 | wr_ctrl1 | wr_cmp1 | wr_stat | (wr_addr == `TIC_ADDR_COUNT) |
    (wr_addr == `TIC_ADDR_CAPTURE);
wire [31:0] ctrl0_new = merge(first_control_reg, wr_data, wr_strb) & `TIC_C0_MASK;
wire [31:0] ctrl1_new = merge(second_control_reg, wr_data, wr_strb) & `TIC_C1_MASK;
wire [31:0] cmp1_new = merge({16'h0000, compare1_value_reg}, wr_data, wr_strb);

reg [31:0] rd_data;
reg rd_ok;
always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `TIC_ADDR_COUNT: rd_data = {16'h0000, timer_count_reg};
        `TIC_ADDR_CAPTURE: rd_data = {16'h0000, capture_value_reg};
        `TIC_ADDR_COMPARE1: rd_data = {16'h0000, compare1_value_reg};
        `TIC_ADDR_CTRL0: rd_data = first_control_reg;
        `TIC_ADDR_CTRL1: rd_data = second_control_reg;
        `TIC_ADDR_STATUS: rd_data = {30'h0000_0000, status_reg};
        default: begin
            rd_data = `TIC_ZERO32;
            rd_ok = 1'b0;
        end
    endcase
end

// ********************************
// sequential logic
// ********************************
always @(posedge aclk) begin
    if (!aresetn) begin
        timer_count_reg <= `TIC_COUNT_ZERO;
        capture_value_reg <= `TIC_COUNT_ZERO;
        compare1_value_reg <= `TIC_COUNT_ZERO;
        first_control_reg <= `TIC_ZERO32;
        second_control_reg <= `TIC_ZERO32;
        status_reg <= 2'h0;
        prescale_reg <= 5'h00;
        fprescale_reg <= 5'h00;
        pin_sync1_reg <= 1'b0;
        pin_sync2_reg <= 1'b0;
        match_cnt_reg <= 2'h0;
        filt_level_reg <= 1'b0;
        filt_prev_reg <= 1'b0;
        aw_addr_reg <= 5'h00;
        aw_held_reg <= 1'b0;
        w_data_reg <= `TIC_ZERO32;
        w_strb_reg <= 4'h0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TIC_RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `TIC_RESP_OKAY;
        s_axi_rdata <= `TIC_ZERO32;
        capture_irq_pulse <= 1'b0;
        overflow_irq_pulse <= 1'b0;
        compare_output_oe <= 1'b0;
    end else begin
        prescale_reg <= prescale_reg + 5'h01;
        fprescale_reg <= fprescale_reg + 5'h01;
        pin_sync1_reg <= measured_pulse_in;
        pin_sync2_reg <= pin_sync1_reg;
        // three equal samples in a row settle the filtered level; while the
        // filter is off it shadows the pin, so enabling it raises no false edge
        if (!filter_en) begin
            filt_level_reg <= pin_sync2_reg;
            match_cnt_reg <= 2'h0;
        end else if (filt_tick) begin
            if (pin_sync2_reg == filt_level_reg) begin
                match_cnt_reg <= 2'h0;
            end else if (match_cnt_reg == `TIC_FILT_FULL) begin
                filt_level_reg <= pin_sync2_reg;
                match_cnt_reg <= 2'h0;
            end else begin
                match_cnt_reg <= match_cnt_reg + 2'h1;
            end
        end
        filt_prev_reg <= in_level;

        // counter; stop clears it, overflow wraps to zero
        if (!count_run_bit) begin
            timer_count_reg <= `TIC_COUNT_ZERO;
        end else if (count_tick) begin
            timer_count_reg <= timer_count_reg + 16'h0001;
        end
        if (capture_hit) begin
            capture_value_reg <= timer_count_reg;
        end
        capture_irq_pulse <= capture_hit;
        overflow_irq_pulse <= overflow_hit;
        // output-compare waveform not built; pins stay with the port logic
        compare_output_oe <= 1'b0;

        // ********************************
        // sticky status
        // ********************************
        // set wins over write-1-clear so an event in the clear cycle is kept
        status_reg[`TIC_ST_CAP] <= capture_hit |
            (status_reg[`TIC_ST_CAP] & ~(wr_stat & wr_strb[0] & wr_data[`TIC_ST_CAP]));
        status_reg[`TIC_ST_OVF] <= overflow_hit |
            (status_reg[`TIC_ST_OVF] & ~(wr_stat & wr_strb[0] & wr_data[`TIC_ST_OVF]));

        // ********************************
        // register bus
        // ********************************
        // write channel capture, either order; readies toggle while idle,
        // so a master must hold its valids until the handshake
        s_axi_awready <= ~aw_held_reg & ~s_axi_awready & ~s_axi_bvalid;
        s_axi_wready <= ~w_held_reg & ~s_axi_wready & ~s_axi_bvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
            if (wr_ctrl0) begin
                first_control_reg <= ctrl0_new;
            end
            if (wr_ctrl1) begin
                second_control_reg <= ctrl1_new;
            end
            // count and capture accept no writes in any mode; such a write is answered okay and dropped
            if (wr_cmp1) begin
                compare1_value_reg <= cmp1_new[15:0];
            end
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end

        // read channel; read data follows araddr live, so araddr must stand until arready
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
        end
        if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ===== verification/tic_pulse_model.sv
// measured-pulse source for the capture pin
`timescale 1ns/1ps
`default_nettype none
module tic_pulse_model (
    input wire logic aclk,
    input wire logic go,
    input wire logic [7:0] width,
    output wire logic pin
);
    logic [7:0] left_reg = 8'h00;
    // edges land on aclk, yet the pin still passes the design's synchroniser
    always @(posedge aclk) begin
        if (go) begin
            left_reg <= width;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    assign pin = (left_reg != 8'h00);
endmodule
`default_nettype wire

// ===== verification/tic_timer_monitor.sv
// port-level assertion checker for the input-capture timer
`timescale 1ns/1ps
`default_nettype none
`include "tic_consts.vh"
module tic_timer_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic capture_irq_pulse,
    input wire logic overflow_irq_pulse,
    input wire logic compare_output_oe
);
    // ********************************
    // helper logic and assertions
    // ********************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [16:0] gap_reg;
    logic seen_reg;
    // gap saturates, so a long stop never wraps into a false alarm
    always_ff @(posedge aclk) begin
        if (!aresetn || overflow_irq_pulse) begin
            gap_reg <= 17'h0_0000;
        end else if (gap_reg != 17'h1_ffff) begin
            gap_reg <= gap_reg + 17'h0_0001;
        end
        seen_reg <= aresetn && (seen_reg || overflow_irq_pulse);
    end
    oe_idle_a: assert property (compare_output_oe == 1'b0)
        else $error("compare output enabled");
    cap_pulse_a: assert property (capture_irq_pulse |=> !capture_irq_pulse)
        else $error("capture pulse too long");
    ovf_gap_a: assert property (overflow_irq_pulse |-> !seen_reg || gap_reg >= 17'd65535)
        else $error("overflow too soon");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h14 |=>
        s_axi_rresp == `TIC_RESP_SLVERR && s_axi_rdata == `TIC_ZERO32) else $error("unmapped read answered");
    cap_seen_c: cover property (capture_irq_pulse);
    ovf_seen_c: cover property (overflow_irq_pulse);
    err_seen_c: cover property (s_axi_rvalid && s_axi_rresp == `TIC_RESP_SLVERR);
endmodule
bind tic_timer tic_timer_monitor u_mon (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .capture_irq_pulse,
    .overflow_irq_pulse, .compare_output_oe);
`default_nettype wire

// ===== verification/timer_input_capture_16bit_tb_top.sv
// self-checking bench for the input-capture timer
`timescale 1ns/1ps
`default_nettype none
`include "tic_consts.vh"
module timer_input_capture_16bit_tb_top;
    localparam logic [4:0] a_cnt = `TIC_ADDR_COUNT, a_cap = `TIC_ADDR_CAPTURE, a_c0 = `TIC_ADDR_CTRL0;
    localparam logic [4:0] a_c1 = `TIC_ADDR_CTRL1, a_st = `TIC_ADDR_STATUS;
    localparam logic [1:0] ok_r = `TIC_RESP_OKAY, er_r = `TIC_RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, c, rnd;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, go, awready, wready, bvalid, arready, rvalid, cap, ovf, oe;
    logic [1:0] bresp, rresp;
    logic [7:0] pw;
    wire logic pin;
    int cyc = 0, cap_n = 0, ovf_n = 0, bad_count = 0, n_compared = 0, t, t1, t2, n0, k, e;
    int divs[3] = '{1, 8, 32};
    logic [31:0] fc[6] = '{0, 4, 4, 5, 5, 8}, fw[6] = '{2, 2, 6, 6, 60, 6}, fx[6] = '{1, 0, 1, 0, 1, 0};
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    always #2 aclk = ~aclk;
    tic_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .measured_pulse_in(pin),
        .capture_irq_pulse(cap), .overflow_irq_pulse(ovf), .compare_output_oe(oe));
    tic_pulse_model u_src (.aclk(aclk), .go(go), .width(pw), .pin(pin));
    // ********************************
    // checking and bus tasks
    // ********************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic stall();
        bad_count++;
        $display("wait limit reached");
        complete_run();
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] r);
        int i;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 64) stall();
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [31:0] m, input logic [1:0] r,
        output logic [31:0] v, output int ts);
        int i;
        rq.push_back({r, m, x & m});
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            v = rdata;
            ts = cyc;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (i == 64) stall();
    endtask
    task automatic fire(input logic [31:0] w);
        @(posedge aclk);
        go <= 1'b1;
        pw <= w[7:0];
        @(posedge aclk);
        go <= 1'b0;
    endtask
    // scoreboard: oldest note is compared as each answer appears
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        cap_n <= cap_n + int'(cap === 1'b1);
        ovf_n <= ovf_n + int'(ovf === 1'b1);
        if (rvalid && rready && rq.size() > 0) begin
            chk("rdata", rdata & rq[0][63:32], rq[0][31:0]);
            chk("rresp", {30'h0, rresp}, {30'h0, rq[0][65:64]});
            void'(rq.pop_front());
        end
        if (bvalid && bready && bq.size() > 0) begin
            chk("bresp", {30'h0, bresp}, {30'h0, bq[0]});
            void'(bq.pop_front());
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, go, pw} = '0;
        wstrb = 4'hf;
        void'($urandom(91142));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rnd = $urandom;
        rd(a_cnt, 32'h0, 32'hffff_ffff, ok_r, d, t);
        wr(`TIC_ADDR_COMPARE1, rnd, ok_r);
        rd(`TIC_ADDR_COMPARE1, rnd, 32'h0000_ffff, ok_r, d, t);
        wr(a_cnt, rnd, ok_r);
        wr(a_cap, ~rnd, ok_r);
        rd(a_cnt, 32'h0, 32'hffff_ffff, ok_r, d, t);
        rd(a_cap, 32'h0, 32'hffff_ffff, ok_r, d, t);
        rd(5'h18, 32'h0, 32'hffff_ffff, er_r, d, t);
        wr(5'h1c, rnd, er_r);
        $display("registers test done");
        wr(a_c1, 32'h0, ok_r);
        for (e = 0; e < 4; e++) begin
            wr(a_c0, 32'(1 + 8 * e), ok_r);
            n0 = cap_n;
            fire(20);
            repeat (12) @(posedge aclk);
            chk("rise", 32'(cap_n - n0), 32'(e == 0 || e == 2));
            n0 = cap_n;
            repeat (30) @(posedge aclk);
            chk("fall", 32'(cap_n - n0), 32'(e == 1 || e == 2));
        end
        $display("edge test done");
        chk("oe", {31'h0, oe}, 32'h0);
        wr(a_c0, 32'h0, ok_r);
        wr(a_st, 32'h3, ok_r);
        wr(a_c0, 32'h5, ok_r);
        repeat (300) @(posedge aclk);
        n0 = cap_n;
        fire(8);
        for (k = 0; k < 100 && cap_n == n0; k++) @(posedge aclk);
        if (cap_n == n0) stall();
        rd(a_cap, 32'h0, 32'h0, ok_r, c, t);
        rd(a_cnt, 32'h0, 32'h0, ok_r, d, t);
        chk("capture_near", 32'(d - c < 2), 32'h1);
        chk("capture_live", 32'(c > 5), 32'h1);
        rd(a_st, 32'h1, 32'h1, ok_r, d, t);
        wr(a_st, 32'h1, ok_r);
        rd(a_st, 32'h0, 32'h1, ok_r, d, t);
        $display("capture test done");
        for (e = 0; e < 3; e++) begin
            wr(a_c0, 32'(25 + 2 * e), ok_r);
            rd(a_cnt, 32'h0, 32'h0, ok_r, c, t1);
            repeat (400) @(posedge aclk);
            rd(a_cnt, 32'h0, 32'h0, ok_r, d, t2);
            k = int'(d - c) - (t2 - t1) / divs[e];
            chk("tick_rate", 32'(k >= -1 && k <= 1), 32'h1);
            wr(a_c0, 32'h0, ok_r);
            rd(a_cnt, 32'h0, 32'h0000_ffff, ok_r, d, t);
        end
        $display("clock test done");
        for (e = 0; e < 6; e++) begin
            wr(a_c0, 32'h0, ok_r);
            wr(a_c1, fc[e], ok_r);
            wr(a_c0, 32'h1, ok_r);
            n0 = cap_n;
            fire(fw[e]);
            repeat (100) @(posedge aclk);
            chk("filter", 32'(cap_n - n0), fx[e]);
        end
        $display("filter test done");
        wr(a_c0, 32'h0, ok_r);
        wr(a_c1, 32'h0, ok_r);
        wr(a_c0, 32'h19, ok_r);
        t1 = cyc;
        n0 = ovf_n;
        for (k = 0; k < 70000 && ovf_n == n0; k++) @(posedge aclk);
        if (ovf_n == n0) stall();
        chk("ovf_period", 32'(cyc - t1 >= 65530 && cyc - t1 <= 65540), 32'h1);
        rd(a_cnt, 32'h0, 32'h0, ok_r, d, t);
        chk("wrapped", 32'(d < 16), 32'h1);
        rd(a_st, 32'h2, 32'h2, ok_r, d, t);
        $display("overflow test done");
        complete_run();
    end
endmodule
`default_nettype wire
